// [hdl/pca_readout.sv]
// Conversion sequencer and serial result port of the pin configured converter
`timescale 1ns/100ps
`default_nettype none

// How it works
// - New result every 1656 crystal periods, 19.79 Hz, no setting changes it.
// - All timing except slave shifting counts edges of the 32.768 kHz crystal input.
// - One 24-bit result; one of two differential pairs converted at a time.
// - Range pin 0 selects gain 16 (+-160 mV), 1 selects gain 1.
// - No registers; channel and range come only from two pins.
// - Read-only port; mode pin picks serial clock master or slave.
// - Slave reads use chip select, serial clock and data out only.
// - Master holds data/ready low half a crystal period before first edge.
// - Results leave in offset binary.
// - Front end runs whenever chip select is low; chip select high powers down.
// - Master serial clock period equals one crystal period, even halves.
// - Data/ready high while converting, low when ready, high before update.
// - Bits change on falling serial clock; host samples on rising.
// - Chip select high aborts, releases pins, discards held result.
module pca_readout (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic crystal_osc_input,
  input wire logic cs_n,
  input wire logic input_pair_select,
  input wire logic range_sel,
  input wire logic mode_sel,
  input wire logic sclk_in,
  input wire logic [pca_pkg::RES_MSB:0] filter_word,
  output logic sclk_out,
  output logic sclk_oe,
  output logic dout_rdy_out,
  output logic dout_rdy_oe,
  output pca_pkg::pca_fe_s fe_ctrl
);
  import pca_pkg::*;

  logic [PIN_N-1:0] pin_meta_reg;
  logic [PIN_N-1:0] pin_sync_reg;
  logic [PIN_N-1:0] pin_prev_reg;
  pca_state_e state_reg;
  logic [10:0] tick_reg;
  logic [RES_MSB:0] shift_reg;
  logic [4:0] bit_reg;
  logic xtal_rise;
  logic xtal_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_high;
  logic master;
  logic update;
  logic shift_ev;
  logic end_ev;

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************

  // Two flops on every pin from outside, then one more for edges
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_meta_reg <= PIN_RESET;
      pin_sync_reg <= PIN_RESET;
      pin_prev_reg <= PIN_RESET;
    end else begin
      pin_meta_reg <= {sclk_in, mode_sel, range_sel, input_pair_select,
                       cs_n, crystal_osc_input};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  // Crystal and serial clock edges, all on the second flop onward
  assign xtal_rise = pin_sync_reg[PIN_XTAL] & ~pin_prev_reg[PIN_XTAL];
  assign xtal_fall = ~pin_sync_reg[PIN_XTAL] & pin_prev_reg[PIN_XTAL];
  assign sclk_rise = pin_sync_reg[PIN_SCLK] & ~pin_prev_reg[PIN_SCLK];
  assign sclk_fall = ~pin_sync_reg[PIN_SCLK] & pin_prev_reg[PIN_SCLK];
  assign cs_high = pin_sync_reg[PIN_CS_N];
  assign master = (pin_sync_reg[PIN_MODE] == MODE_MASTER);

  // Result update at the last crystal period of a conversion
  assign update = xtal_rise && (tick_reg == CONV_LAST);

  // Shift and end events from the clock owner of the current mode
  assign shift_ev = master ? xtal_fall : sclk_fall;
  assign end_ev = master ? xtal_rise : sclk_rise;

  // ****************************************************************
  // Conversion timing
  // ****************************************************************

  // Crystal period counter, restarted whenever the part is deselected
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tick_reg <= TICK_ZERO;
    end else if (cs_high) begin
      tick_reg <= TICK_ZERO;
    end else if (xtal_rise) begin
      if (tick_reg == CONV_LAST) begin
        tick_reg <= TICK_ZERO;
      end else begin
        tick_reg <= tick_reg + 11'h001;
      end
    end
  end

  // Front end control straight from the chip select, channel and range pins
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fe_ctrl <= FE_OFF;
    end else begin
      fe_ctrl.run <= ~cs_high;
      fe_ctrl.pair_sel <= pin_sync_reg[PIN_PAIR];
      fe_ctrl.gain16 <= (pin_sync_reg[PIN_RANGE] == RANGE_LOW);
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************

  // Standby, converting, ready and shifting
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= PCA_IDLE;
    end else if (cs_high) begin
      state_reg <= PCA_IDLE;
    end else begin
      case (state_reg)
        PCA_IDLE: begin
          state_reg <= PCA_CONV;
        end
        PCA_CONV: begin
          if (update) begin
            state_reg <= PCA_READY;
          end
        end
        PCA_READY: begin
          if (shift_ev) begin
            state_reg <= PCA_SHIFT;
          end else if (!master && xtal_rise && tick_reg == UNREAD_DROP) begin
            state_reg <= PCA_CONV;
          end
        end
        PCA_SHIFT: begin
          if (end_ev && bit_reg == RES_BITS) begin
            state_reg <= PCA_CONV;
          end
        end
        default: begin
          state_reg <= PCA_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Serial shifter
  // ****************************************************************

  // Load at update with the sign bit flipped to offset binary, MSB first
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      shift_reg <= RES_ZERO;
      bit_reg <= BIT_ZERO;
    end else if (cs_high) begin
      shift_reg <= RES_ZERO;
      bit_reg <= BIT_ZERO;
    end else if (state_reg == PCA_CONV && update) begin
      shift_reg <= {~filter_word[RES_MSB], filter_word[RES_MSB-1:0]};
      bit_reg <= BIT_ZERO;
    end else if ((state_reg == PCA_READY || state_reg == PCA_SHIFT) &&
                 shift_ev && bit_reg != RES_BITS) begin
      shift_reg <= {shift_reg[RES_MSB-1:0], 1'b0};
      bit_reg <= bit_reg + 5'h01;
    end
  end

  // Data/ready pin: high converting, low ready, bits while shifting
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dout_rdy_out <= 1'b1;
      dout_rdy_oe <= 1'b0;
    end else if (cs_high) begin
      dout_rdy_out <= 1'b1;
      dout_rdy_oe <= 1'b0;
    end else begin
      dout_rdy_oe <= 1'b1;
      case (state_reg)
        PCA_READY: begin
          if (shift_ev) begin
            dout_rdy_out <= shift_reg[RES_MSB];
          end else if (!master && xtal_rise && tick_reg == UNREAD_DROP) begin
            dout_rdy_out <= 1'b1;
          end else begin
            dout_rdy_out <= 1'b0;
          end
        end
        PCA_SHIFT: begin
          if (end_ev && bit_reg == RES_BITS) begin
            dout_rdy_out <= 1'b1;
          end else if (shift_ev && bit_reg != RES_BITS) begin
            dout_rdy_out <= shift_reg[RES_MSB];
          end
        end
        PCA_CONV: begin
          dout_rdy_out <= ~update;
        end
        default: begin
          dout_rdy_out <= 1'b1;
        end
      endcase
    end
  end

  // Master clock: idles high, follows crystal halves while shifting
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sclk_out <= 1'b1;
      sclk_oe <= 1'b0;
    end else if (cs_high || !master) begin
      sclk_out <= 1'b1;
      sclk_oe <= 1'b0;
    end else begin
      sclk_oe <= 1'b1;
      if ((state_reg == PCA_READY || state_reg == PCA_SHIFT) && xtal_fall &&
          bit_reg != RES_BITS) begin
        sclk_out <= 1'b0;
      end else if (xtal_rise) begin
        sclk_out <= 1'b1;
      end
    end
  end

endmodule : pca_readout

`default_nettype wire

// [hdl/pca_pkg.sv]
// Shared constants and carrier types for the pin configured converter readout
package pca_pkg;

  // ****************************************************************
  // Timing figures
  // ****************************************************************
  localparam real XTAL_FREQ_KHZ = 32.768;   // Crystal frequency
  localparam real XTAL_PERIOD_US = 30.5176; // Crystal period
  localparam real CONV_RATE_HZ = 19.79;     // Result update rate
  localparam real CONV_PERIOD_MS = 50.54;   // Result update period
  // Crystal periods per result: the filter decimation chain 69 x 8 x 3
  localparam int DECIM_A = 69;
  localparam int DECIM_B = 8;
  localparam int DECIM_C = 3;
  localparam int CONV_TICKS_INT = DECIM_A * DECIM_B * DECIM_C;
  localparam logic [10:0] CONV_TICKS = 11'(CONV_TICKS_INT);
  localparam logic [10:0] CONV_LAST = 11'(CONV_TICKS_INT - 1);
  // Unread result: ready drops one crystal period before update, at tick UNREAD_DROP
  localparam logic [10:0] UNREAD_LEAD = 11'h002;
  localparam logic [10:0] UNREAD_DROP = 11'(CONV_TICKS_INT - 2);

  // ****************************************************************
  // Result word
  // ****************************************************************
  localparam int RES_W = 24;
  localparam int RES_MSB = RES_W - 1;
  localparam logic [4:0] RES_BITS = 5'h18;  // Bits per result
  localparam logic [4:0] BIT_ZERO = 5'h00;
  localparam logic [23:0] RES_ZERO = 24'h000000;
  localparam logic [10:0] TICK_ZERO = 11'h000;

  // Pin levels
  localparam logic MODE_MASTER = 1'b0;  // Mode pin low selects master
  localparam logic RANGE_LOW = 1'b0;    // Range 0: +-160 mV, gain 16

  // Synchronised pin vector positions
  localparam int PIN_XTAL = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_PAIR = 2;
  localparam int PIN_RANGE = 3;
  localparam int PIN_MODE = 4;
  localparam int PIN_SCLK = 5;
  localparam int PIN_N = 6;
  localparam logic [5:0] PIN_RESET = 6'h22; // Chip select and clock idle high

  // Sequencer states
  typedef enum logic [1:0] {
    PCA_IDLE = 2'b00,   // Standby, pins released
    PCA_CONV = 2'b01,   // Converting, ready line high
    PCA_READY = 2'b10,  // Result waiting, ready line low
    PCA_SHIFT = 2'b11   // Shifting result out
  } pca_state_e;

  // Analog front end control
  typedef struct packed {
    logic run;       // Modulator running (normal mode)
    logic pair_sel;  // 0: first input pair, 1: second
    logic gain16;    // PGA gain 16 when set, else gain 1
  } pca_fe_s;

  localparam pca_fe_s FE_OFF = '{run: 1'b0, pair_sel: 1'b0, gain16: 1'b0};

endpackage : pca_pkg

// [test/pca_readout_monitor.sv]
// Port checker for the converter readout
`timescale 1ns/100ps
`default_nettype none
module pca_readout_monitor (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk_out,
  input wire logic sclk_oe,
  input wire logic dout_rdy_out,
  input wire logic dout_rdy_oe,
  input wire pca_pkg::pca_fe_s fe_ctrl
);
  import pca_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Master ready fall, then low lead before first clock fall
  // A data bit that falls does so with the clock low; ready falls with it high
  sequence rdy_fall_s;
    $fell(dout_rdy_out) && sclk_oe && sclk_out;
  endsequence
  sequence lead_s;
    (sclk_out && !dout_rdy_out) [*4] ##[1:8] !sclk_out;
  endsequence
  chk_rdy_lead: assert property (disable iff (!rst_n || cs_n)
    rdy_fall_s |-> lead_s) else $error("ready lead wrong");
  chk_sclk_half: assert property (disable iff (!rst_n || cs_n)
    $fell(sclk_out) |-> !sclk_out [*4] ##1 sclk_out) else $error("half");
  chk_data_hold: assert property (
    sclk_oe && !sclk_out && !$fell(sclk_out) |-> $stable(dout_rdy_out))
    else $error("data moved");
  chk_cs_release: assert property (
    $rose(cs_n) |-> ##[1:4] !dout_rdy_oe && !sclk_oe) else $error("cs");
  chk_conv_high: assert property (
    $rose(dout_rdy_oe) |-> dout_rdy_out [*8]) else $error("conv");
  chk_oe_pair: assert property (
    sclk_oe |-> dout_rdy_oe) else $error("oe pair");
  chk_standby_run: assert property (
    !dout_rdy_oe |-> !fe_ctrl.run) else $error("run");
  chk_idle_high: assert property (
    !dout_rdy_oe |-> dout_rdy_out && sclk_out) else $error("idle");
endmodule : pca_readout_monitor
bind pca_readout pca_readout_monitor i_mon (.mclk(mclk), .rst_n(rst_n),
  .cs_n(cs_n), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
  .dout_rdy_out(dout_rdy_out), .dout_rdy_oe(dout_rdy_oe),
  .fe_ctrl(fe_ctrl));
`default_nettype wire

// [test/pca_host_model.sv]
// Host that clocks results out in slave mode
`timescale 1ns/100ps
`default_nettype none
module pca_host_model (
  input wire logic mclk,
  input wire logic dout,
  input wire logic start,
  output logic sclk,
  output logic [pca_pkg::RES_MSB:0] word,
  output logic done
);
  import pca_pkg::*;
  // Clock idles high; data taken at each rising edge
  initial begin
    sclk = 1'b1;
    word = RES_ZERO;
    done = 1'b0;
    forever begin
      @(posedge mclk);
      if (start) begin
        done <= 1'b0;
        for (int i = 0; i < RES_W; i++) begin
          sclk <= 1'b0;
          repeat (5) @(posedge mclk);
          sclk <= 1'b1;
          word <= {word[RES_MSB-1:0], dout};
          repeat (5) @(posedge mclk);
        end
        done <= 1'b1;
      end
    end
  end
endmodule : pca_host_model
`default_nettype wire

// [test/test_pca_readout.sv]
// Self-checking bench for the converter readout
`timescale 1ns/100ps
`default_nettype none
module test_pca_readout;
  import pca_pkg::*;
  localparam int XT = 8; // Crystal period in clocks
  logic mclk, rst_n, xtal, cs_n, pair, rng, mode, h_start;
  logic sclk_out, sclk_oe, rdy, rdy_oe, h_sclk, h_done, ps, cur;
  logic sclk_in, dline;
  logic [23:0] fword, hword, w;
  pca_fe_s fe;
  logic [4:0] rows [4] = '{5'h05, 5'h17, 5'h0c, 5'h1e};
  int num_errors = 0, n_compared = 0, cyc = 0, t1, n;
  // Released data line shows the inverse of the driven level
  assign dline = rdy_oe ? rdy : ~rdy;
  assign sclk_in = sclk_oe ? sclk_out : h_sclk;
  pca_readout i_pca_readout (.mclk(mclk), .rst_n(rst_n),
    .crystal_osc_input(xtal), .cs_n(cs_n), .input_pair_select(pair),
    .range_sel(rng), .mode_sel(mode), .sclk_in(sclk_in),
    .filter_word(fword), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .dout_rdy_out(rdy), .dout_rdy_oe(rdy_oe), .fe_ctrl(fe));
  pca_host_model i_pca_host_model (.mclk(mclk), .dout(dline),
    .start(h_start), .sclk(h_sclk), .word(hword), .done(h_done));
  // Clocks and cycle count
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    xtal = 0;
    #30;
    forever #400 xtal = ~xtal;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  task chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task final_report;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // Bounded wait for ready line or host done
  task wait_for(input int sel, input logic lvl);
    int k;
    for (k = 0; k < 20000; k++) begin
      @(negedge mclk);
      if ((sel == 0 ? rdy : h_done) === lvl) break;
    end
    if (k == 20000) begin
      num_errors++;
      $display("MISMATCH wait expected %b seen timeout", lvl);
      final_report;
    end
  endtask : wait_for
  // Main sequence
  initial begin
    rst_n = 0; cs_n = 1; pair = 0; rng = 0; mode = 0; h_start = 0;
    fword = 24'h123456;
    repeat (5) @(posedge mclk);
    rst_n <= 1;
    @(negedge mclk);
    chk("idle", 24'h000050,
      {17'h0, sclk_out, sclk_oe, rdy, rdy_oe, fe});
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      cs_n <= 1;
      pair <= rows[i][4];
      rng <= rows[i][3];
      repeat (5) @(posedge mclk);
      cs_n <= 0;
      repeat (8) @(negedge mclk);
      chk("fe", {21'h0, rows[i][2:0]},
        {21'h0, fe});
    end
    wait_for(0, 1'b0);
    t1 = cyc;
    n = 0; ps = 1; w = 0; cur = 0;
    for (int k = 0; k < 400 && n < 24; k++) begin
      @(negedge mclk);
      if (sclk_out && !ps) begin
        w = {w[22:0], cur};
        n++;
      end
      if (!sclk_out) cur = rdy;
      ps = sclk_out;
    end
    chk("master", 24'h923456, w);
    wait_for(0, 1'b1);
    wait_for(0, 1'b0);
    chk("period", 24'(CONV_TICKS_INT * XT), 24'(cyc - t1));
    repeat (60) @(negedge mclk);
    @(posedge mclk);
    cs_n <= 1;
    repeat (5) @(negedge mclk);
    chk("abort", 24'h000001,
      {20'h0, rdy_oe, sclk_oe, fe.run, rdy});
    @(posedge mclk);
    mode <= 1; fword <= 24'h00ff0f; cs_n <= 0;
    wait_for(0, 1'b0);
    @(posedge mclk);
    h_start <= 1;
    @(posedge mclk);
    h_start <= 0;
    wait_for(1, 1'b1);
    chk("slave", 24'h80ff0f, hword);
    repeat (8) @(negedge mclk);
    chk("after", 24'h000001, {23'h0, rdy});
    wait_for(0, 1'b0);
    t1 = cyc;
    wait_for(0, 1'b1);
    n = cyc - t1;
    chk("unread", 24'h000001,
      {23'h0, n > (CONV_TICKS_INT - 3) * XT && n < CONV_TICKS_INT * XT});
    final_report;
  end
endmodule : test_pca_readout
`default_nettype wire
